// ---- core/bloc_pkg.sv ----
package bloc_pkg;

    localparam logic [11:0] BLOC_OFF_BOOT_LIMIT = 12'h000;
    localparam logic [11:0] BLOC_OFF_SIGNATURE = 12'h004;
    localparam logic [11:0] BLOC_OFF_OSC_SELECT = 12'h008;
    localparam logic [11:0] BLOC_OFF_CONTROL = 12'h00c;
    localparam logic [11:0] BLOC_OFF_STATUS = 12'h010;

    localparam int BLOC_WORD_W = 24;
    localparam int BLOC_LIMIT_W = 13;

    localparam logic [23:0] BLOC_BOOT_LIMIT_ONES = 24'hff_e000;
    localparam logic [23:0] BLOC_SIGNATURE_READ = 24'hff_7fff;
    localparam logic [23:0] BLOC_SIGNATURE_RSVD = 24'h00_8000;
    localparam logic [23:0] BLOC_OSC_ONES = 24'hff_fc00;
    localparam logic [23:0] BLOC_OSC_RSVD = 24'h00_0300;
    localparam logic [12:0] BLOC_LIMIT_ERASED = 13'h1fff;
    localparam logic [23:0] BLOC_WORD_ERASED = 24'hff_ffff;

    localparam int BLOC_TWO_SPEED_BIT = 7;
    localparam int BLOC_MULT_LSB = 3;
    localparam int BLOC_OSC_LSB = 0;

    localparam logic [31:0] BLOC_CTRL_LOAD = 32'h0000_0001;

    typedef enum logic [3:0] {
        BLOC_MULT_OFF = 4'b1111,
        BLOC_MULT_X8 = 4'b1110,
        BLOC_MULT_X6 = 4'b1101,
        BLOC_MULT_96_FROM_24 = 4'b0101,
        BLOC_MULT_96_FROM_20 = 4'b0100,
        BLOC_MULT_96_FROM_16 = 4'b0011,
        BLOC_MULT_96_FROM_4 = 4'b0001
    } bloc_mult_t;

    typedef enum logic [2:0] {
        BLOC_OSC_FAST_RC = 3'b000,
        BLOC_OSC_FAST_RC_MULT = 3'b001,
        BLOC_OSC_PRIMARY = 3'b010,
        BLOC_OSC_PRIMARY_MULT = 3'b011,
        BLOC_OSC_SECONDARY = 3'b100,
        BLOC_OSC_LOW_POWER_RC = 3'b101,
        BLOC_OSC_RESERVED = 3'b110,
        BLOC_OSC_DIVIDED = 3'b111
    } bloc_osc_t;

    typedef struct packed {
        logic [12:0] boot_limit_page;
        logic boot_segment_empty;
        logic two_speed_startup_en;
        logic [2:0] start_osc;
        logic [2:0] target_osc;
        logic multiplier_en;
        logic [3:0] mult_factor;
        logic [3:0] mult_input_mhz_div4;
        logic mult_code_unknown;
        logic osc_code_reserved;
    } bloc_clock_cfg_t;

    typedef enum logic [1:0] {
        BLOC_ST_ERASED = 2'b00,
        BLOC_ST_LOADED = 2'b01
    } bloc_state_t;

endpackage

// ---- core/bloc_config_loader.sv ----
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - Limit field names first general segment page
// - Limit page is the inverted stored field
// - All-ones limit means empty boot segment
// - Limit word bits 23-13 read one
// - Signature bit 15 kept zero, rest one
// - Fields readable, program once, erased ones
// - Two-speed: start fast RC, then switch
// - No two-speed: start on selected source
// - Multiplier code 1111 disables multiplier
// - Codes 1110 eight-times, 1101 six-times
// - Codes 0101/0100: 96 MHz from 24/20
// - Codes 0011/0001: 96 MHz from 16/4
// - Source 111 divided, 110 reserved
// - Source 101 low-power RC, 100 secondary
// - Source 011 primary multiplied, 010 primary
// - Source 001 fast RC multiplied, 000 direct
module bloc_config_loader (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_ready,
    output bloc_pkg::bloc_clock_cfg_t clock_cfg,
    output logic [2:0] active_osc
);
    import bloc_pkg::*;

    bloc_state_t state_q, state_d;
    logic [23:0] limit_word_q, limit_word_d;
    logic [23:0] sig_word_q, sig_word_d;
    logic [23:0] osc_word_q, osc_word_d;
    logic [12:0] limit_prog_q, limit_prog_d;
    logic [23:0] osc_prog_q, osc_prog_d;
    logic sig_prog_q, sig_prog_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    bloc_clock_cfg_t cfg_q, cfg_d;
    logic [2:0] active_q, active_d;
    logic switched_q, switched_d;

    function automatic logic [31:0] bloc_extend(input logic [23:0] w);
        return {8'h00, w};
    endfunction

    // Program-once cells only lose ones, so a write is an AND
    function automatic logic [23:0] bloc_program(input logic [23:0] old, input logic [23:0] wr);
        return old & wr;
    endfunction

    logic access;
    assign access = psel && penable && !pready_q;

    // Only a control write with the load bit set re-latches and restarts start-up
    logic load_req;
    assign load_req = access && pwrite && paddr == BLOC_OFF_CONTROL
        && (pwdata & BLOC_CTRL_LOAD) != 32'h0000_0000;

    // Shadow words, programmed once through the bus
    always_comb begin
        state_d = state_q;
        limit_word_d = limit_word_q;
        sig_word_d = sig_word_q;
        osc_word_d = osc_word_q;
        limit_prog_d = limit_prog_q;
        osc_prog_d = osc_prog_q;
        sig_prog_d = sig_prog_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (access) begin
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                BLOC_OFF_BOOT_LIMIT: begin
                    if (pwrite) begin
                        if (!limit_prog_q[0]) begin
                            // Upper bits stay forced to one
                            limit_word_d = bloc_program(limit_word_q, pwdata[23:0])
                                | BLOC_BOOT_LIMIT_ONES;
                            limit_prog_d = {BLOC_LIMIT_W{1'b1}};
                        end else begin
                            pslverr_d = 1'b1;
                        end
                    end else begin
                        prdata_d = bloc_extend(limit_word_q | BLOC_BOOT_LIMIT_ONES);
                    end
                end
                BLOC_OFF_SIGNATURE: begin
                    if (pwrite) begin
                        if (!sig_prog_q) begin
                            sig_word_d = (bloc_program(sig_word_q, pwdata[23:0])
                                & BLOC_SIGNATURE_RSVD) | BLOC_SIGNATURE_READ;
                            sig_prog_d = 1'b1;
                        end else begin
                            pslverr_d = 1'b1;
                        end
                    end else begin
                        prdata_d = bloc_extend(sig_word_q | BLOC_SIGNATURE_READ);
                    end
                end
                BLOC_OFF_OSC_SELECT: begin
                    if (pwrite) begin
                        if (!osc_prog_q[0]) begin
                            osc_word_d = bloc_program(osc_word_q, pwdata[23:0])
                                | BLOC_OSC_ONES;
                            osc_prog_d = BLOC_WORD_ERASED;
                        end else begin
                            pslverr_d = 1'b1;
                        end
                    end else begin
                        prdata_d = bloc_extend(osc_word_q | BLOC_OSC_ONES);
                    end
                end
                BLOC_OFF_CONTROL: begin
                    // Load acts like a device reset re-reading the words
                    if (pwrite && (pwdata & BLOC_CTRL_LOAD) != 32'h0000_0000) begin
                        state_d = BLOC_ST_LOADED;
                    end
                end
                BLOC_OFF_STATUS: begin
                    if (!pwrite) begin
                        prdata_d = {24'h00_0000, cfg_q.osc_code_reserved,
                            cfg_q.mult_code_unknown, switched_q, active_q,
                            (osc_word_q & BLOC_OSC_RSVD) != 24'h00_0000,
                            state_q == BLOC_ST_LOADED};
                    end
                end
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    // Decode of the latched words; updated only at reset or load
    always_comb begin
        logic [3:0] mc;
        logic [2:0] oc;
        mc = osc_word_q[BLOC_MULT_LSB +: 4];
        oc = osc_word_q[BLOC_OSC_LSB +: 3];
        cfg_d = cfg_q;
        if (load_req) begin
            cfg_d.boot_limit_page = ~limit_word_q[BLOC_LIMIT_W-1:0];
            cfg_d.boot_segment_empty =
                limit_word_q[BLOC_LIMIT_W-1:0] == BLOC_LIMIT_ERASED;
            cfg_d.two_speed_startup_en = osc_word_q[BLOC_TWO_SPEED_BIT];
            cfg_d.target_osc = oc;
            cfg_d.start_osc = osc_word_q[BLOC_TWO_SPEED_BIT] ? BLOC_OSC_FAST_RC : oc;
            cfg_d.osc_code_reserved = oc == BLOC_OSC_RESERVED;
            cfg_d.multiplier_en = 1'b1;
            cfg_d.mult_code_unknown = 1'b0;
            cfg_d.mult_factor = 4'h0;
            cfg_d.mult_input_mhz_div4 = 4'h0;
            unique case (mc)
                BLOC_MULT_OFF: cfg_d.multiplier_en = 1'b0;
                BLOC_MULT_X8: cfg_d.mult_factor = 4'h8;
                BLOC_MULT_X6: cfg_d.mult_factor = 4'h6;
                BLOC_MULT_96_FROM_24: cfg_d.mult_input_mhz_div4 = 4'h6;
                BLOC_MULT_96_FROM_20: cfg_d.mult_input_mhz_div4 = 4'h5;
                BLOC_MULT_96_FROM_16: cfg_d.mult_input_mhz_div4 = 4'h4;
                BLOC_MULT_96_FROM_4: cfg_d.mult_input_mhz_div4 = 4'h1;
                // Codes with unclear meaning are passed on flagged
                default: cfg_d.mult_code_unknown = 1'b1;
            endcase
        end
    end

    // Start-up source; two-speed hands over once the target is ready
    always_comb begin
        active_d = active_q;
        switched_d = switched_q;
        if (load_req) begin
            active_d = cfg_d.start_osc;
            switched_d = !cfg_d.two_speed_startup_en;
        end else if (!switched_q && osc_ready) begin
            active_d = cfg_q.target_osc;
            switched_d = 1'b1;
        end
    end

    // Reset values equal the erased cells, decoded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= BLOC_ST_ERASED;
            limit_word_q <= BLOC_WORD_ERASED;
            sig_word_q <= BLOC_SIGNATURE_READ;
            osc_word_q <= BLOC_WORD_ERASED;
            limit_prog_q <= 13'h0000;
            osc_prog_q <= 24'h00_0000;
            sig_prog_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            cfg_q <= '{boot_limit_page: 13'h0000, boot_segment_empty: 1'b1,
                two_speed_startup_en: 1'b1, start_osc: BLOC_OSC_FAST_RC,
                target_osc: BLOC_OSC_DIVIDED, multiplier_en: 1'b0,
                mult_factor: 4'h0, mult_input_mhz_div4: 4'h0,
                mult_code_unknown: 1'b0, osc_code_reserved: 1'b0};
            active_q <= BLOC_OSC_FAST_RC;
            switched_q <= 1'b0;
        end else begin
            state_q <= state_d;
            limit_word_q <= limit_word_d;
            sig_word_q <= sig_word_d;
            osc_word_q <= osc_word_d;
            limit_prog_q <= limit_prog_d;
            osc_prog_q <= osc_prog_d;
            sig_prog_q <= sig_prog_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            cfg_q <= cfg_d;
            active_q <= active_d;
            switched_q <= switched_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign clock_cfg = cfg_q;
    assign active_osc = active_q;

endmodule

// ---- bench/bloc_config_loader_chk.sv ----
`timescale 1ns/100ps
module bloc_config_loader_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_ready,
    input wire bloc_pkg::bloc_clock_cfg_t clock_cfg,
    input wire logic [2:0] active_osc
);
    import bloc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // A load in flight may restart start-up, so only cycles outside an access phase count
    sequence s_waiting;
        osc_ready && !(psel && penable) && active_osc != clock_cfg.target_osc;
    endsequence
    a_ready_latency: assert property (s_access |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside access");
    a_unmapped_zero: assert property (
        pready && !pwrite && paddr > BLOC_OFF_STATUS |-> prdata == 32'h0000_0000 && pslverr)
        else $error("unmapped read not refused");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00)
        else $error("read bits 31:24 not zero");
    a_empty_limit: assert property (
        clock_cfg.boot_segment_empty == (clock_cfg.boot_limit_page == 13'h0000))
        else $error("empty flag disagrees with page");
    a_start_fast: assert property (
        clock_cfg.two_speed_startup_en |-> clock_cfg.start_osc == BLOC_OSC_FAST_RC)
        else $error("two-speed start not on fast RC");
    a_start_direct: assert property (
        !clock_cfg.two_speed_startup_en |-> clock_cfg.start_osc == clock_cfg.target_osc)
        else $error("direct start not on selected source");
    a_switch_ready: assert property (
        s_waiting |-> ##[1:2] active_osc == clock_cfg.target_osc)
        else $error("no switch after oscillator ready");
endmodule
bind bloc_config_loader bloc_config_loader_chk bloc_config_loader_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_ready(osc_ready), .clock_cfg(clock_cfg), .active_osc(active_osc)
);

// ---- bench/boot_limit_and_osc_select_config_tb.sv ----
`timescale 1ns/100ps
module boot_limit_and_osc_select_config_tb;
    import bloc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_ready = 0;
    logic pready, pslverr, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    bloc_clock_cfg_t clock_cfg;
    logic [2:0] active_osc;
    int mismatches = 0, num_checks = 0, cycles = 0;
    bloc_config_loader bloc_config_loader_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_ready(osc_ready), .clock_cfg(clock_cfg),
        .active_osc(active_osc));
    always #12.5 pclk = ~pclk;
    task complete_run;
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits for the answer; only the cycle ceiling ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task restart;
        @(posedge pclk);
        presetn <= 1'b0;
        osc_ready <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // Decode is latched only by the control load, as a device reset would
    task load;
        apb(1'b1, BLOC_OFF_CONTROL, BLOC_CTRL_LOAD);
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task t_erased;
        restart();
        apb(1'b0, BLOC_OFF_BOOT_LIMIT, 0);
        chk(rd, 32'h00ff_ffff);
        apb(1'b0, BLOC_OFF_SIGNATURE, 0);
        chk(rd, 32'h00ff_7fff);
        apb(1'b0, BLOC_OFF_OSC_SELECT, 0);
        chk(rd, 32'h00ff_ffff);
        apb(1'b0, 12'h020, 0);
        chk(rd, 32'h0000_0000);
        chk(er, 1'b1);
        chk(clock_cfg.boot_segment_empty, 1'b1);
    endtask
    task t_limit;
        restart();
        apb(1'b1, BLOC_OFF_BOOT_LIMIT, 32'h0000_1234);
        chk(er, 1'b0);
        apb(1'b1, BLOC_OFF_BOOT_LIMIT, 32'h0000_0000);
        chk(er, 1'b1);
        apb(1'b0, BLOC_OFF_BOOT_LIMIT, 0);
        chk(rd, 32'h00ff_f234);
        apb(1'b1, BLOC_OFF_SIGNATURE, 0);
        apb(1'b0, BLOC_OFF_SIGNATURE, 0);
        chk(rd, 32'h00ff_7fff);
        load();
        chk(clock_cfg.boot_limit_page, 13'h0dcb);
        chk(clock_cfg.boot_segment_empty, 1'b0);
    endtask
    task automatic t_direct;
        logic [3:0] codes [8] = '{4'hf, 4'he, 4'hd, 4'h5, 4'h4, 4'h3, 4'h1, 4'h6};
        logic [3:0] nums [8] = '{4'h0, 4'h8, 4'h6, 4'h6, 4'h5, 4'h4, 4'h1, 4'h0};
        for (int i = 0; i < 8; i++) begin
            restart();
            // Bits 9:8 stay zero as reserved; bit 7 zero means direct start
            apb(1'b1, BLOC_OFF_OSC_SELECT, {25'h0, codes[i], i[2:0]});
            apb(1'b0, BLOC_OFF_OSC_SELECT, 0);
            chk(rd, {24'h00_fffc, 1'b0, codes[i], i[2:0]});
            load();
            chk(active_osc, i[2:0]);
            chk(clock_cfg.start_osc, i[2:0]);
            chk(clock_cfg.osc_code_reserved, i == 6);
            chk(clock_cfg.multiplier_en, i != 0);
            chk(clock_cfg.mult_code_unknown, i == 7);
            if (i > 0 && i < 3) begin
                chk(clock_cfg.mult_factor, nums[i]);
            end
            if (i > 2 && i < 7) begin
                chk(clock_cfg.mult_input_mhz_div4, nums[i]);
            end
        end
    endtask
    task t_two_speed;
        restart();
        // Two-speed on, eight-times multiplier, primary oscillator multiplied
        apb(1'b1, BLOC_OFF_OSC_SELECT, 32'h0000_00f3);
        apb(1'b1, BLOC_OFF_OSC_SELECT, 32'h0000_0000);
        chk(er, 1'b1);
        load();
        chk(clock_cfg.start_osc, BLOC_OSC_FAST_RC);
        repeat (3) @(posedge pclk);
        chk(active_osc, BLOC_OSC_FAST_RC);
        osc_ready <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk(active_osc, BLOC_OSC_PRIMARY_MULT);
        apb(1'b0, BLOC_OFF_STATUS, 0);
        chk(rd, 32'h0000_002d);
    endtask
    initial begin
        t_erased();
        t_limit();
        t_direct();
        t_two_speed();
        complete_run();
    end
endmodule
